//--- bench/lic_config_checker.sv
`timescale 1ns/100ps
`default_nettype none

module lic_config_checker
(
    input wire logic       i_mclk,
    input wire logic       i_reset,
    input wire logic       i_cs_n,
    input wire logic       i_rd_n,
    input wire logic       i_wr_n,
    input wire logic [6:0] i_addr,
    input wire logic       i_one_second_tick_input,
    input wire logic       i_receive_hold_input,
    input wire logic       o_data_oe,
    input wire logic       o_counter_latch,
    input wire logic       o_status_latch,
    input wire logic [7:0] o_phy_onehot,
    input wire logic [5:0] o_cell_octets,
    input wire logic       o_rx_loopback,
    input wire logic       o_ext_timing,
    input wire logic       o_rx_accept,
    input wire logic       o_hec_delineation,
    input wire logic       o_parallel_mode
);
    logic [3:0] arm_q;
    wire logic  armed = (arm_q == 4'h8);

    // decoded outputs are unknown until a config write lands, and
    // they move a few edges after one, so checks wait for it
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
            arm_q <= 4'h0;
        else if ($rose(i_wr_n) && !i_cs_n
                 && i_addr == lic_pkg::LIC_CFG_ADDR)
            arm_q <= 4'h1;
        else if (arm_q != 4'h0 && arm_q != 4'h8)
            arm_q <= arm_q + 4'h1;
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    sequence s_rd_start;
        $fell(i_rd_n) && !i_cs_n;
    endsequence
    sequence s_tick_edge;
        $past(i_one_second_tick_input, 3)
            && !$past(i_one_second_tick_input, 7);
    endsequence

    property p_oct;
        armed |-> o_cell_octets == (o_hec_delineation ? 6'h35 : 6'h39);
    endproperty
    a_oct: assert property (p_oct) else $error("octets");
    property p_loop;
        armed && o_rx_loopback |-> !o_parallel_mode;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback");
    property p_ext;
        armed && o_ext_timing |-> !o_hec_delineation
            && (o_phy_onehot[2] || o_phy_onehot[3]);
    endproperty
    a_ext: assert property (p_ext) else $error("ext timing");
    property p_type;
        armed |-> $onehot(o_phy_onehot);
    endproperty
    a_type: assert property (p_type) else $error("phy type");
    property p_edge;
        (o_counter_latch || o_status_latch) |-> s_tick_edge;
    endproperty
    a_edge: assert property (p_edge) else $error("latch");
    property p_pulse;
        (o_counter_latch || o_status_latch)
            |=> !(o_counter_latch || o_status_latch);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse");
    property p_oe;
        s_rd_start |-> ##[2:4] o_data_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("read enable");
    property p_hold;
        armed && $fell(o_rx_accept) |-> $past(i_receive_hold_input, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
endmodule : lic_config_checker

bind lic_config_reg lic_config_checker u_chk (.*);

`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    typedef struct packed {
        logic [15:0] w;
        logic [7:0]  oh;
        logic [6:0]  c;
        logic [5:0]  o;
        logic [1:0]  le;
    } lic_row_t;
    logic        i_mclk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_cs_n = 1'b1, i_rd_n = 1'b1, i_wr_n = 1'b1;
    logic        i_one_second_tick_input = 1'b0;
    logic        i_receive_hold_input = 1'b0;
    logic        i_transmit_sync_input = 1'b0;
    logic [6:0]  i_addr = 7'h00;
    logic [15:0] i_data = 16'h0000, i_line_status = 16'h0000, rd_v;
    wire logic [15:0] o_data;
    wire logic   o_data_oe, o_counter_latch, o_status_latch, o_rx_accept;
    wire logic   o_rx_loopback, o_ext_timing, o_scramble_en, o_unframed;
    wire logic   o_keep_on_delin_loss, o_hec_delineation, o_ext_framer;
    wire logic   o_parallel_mode, o_coder_bypass, o_overhead_skip;
    wire logic [7:0] o_phy_onehot;
    wire logic [6:0] o_spe_columns;
    wire logic [5:0] o_cell_octets;
    wire logic [6:0] lvl = {o_scramble_en, o_keep_on_delin_loss,
        o_hec_delineation, o_parallel_mode, o_ext_framer, o_coder_bypass,
        o_unframed};
    int          failures = 0, n_checks = 0, nc, ns;
    // word, one-hot type, columns, octets, {loopback, ext timing}
    // DS1/E1 rows keep the coder on
    lic_row_t    rows [9] = '{
        {16'h8080, 8'h01, 7'h54, 6'h35, 2'h0},
        {16'h4001, 8'h02, 7'h56, 6'h39, 2'h2},
        {16'h4842, 8'h04, 7'h56, 6'h39, 2'h1},
        {16'h0883, 8'h08, 7'h56, 6'h35, 2'h0},
        {16'h0804, 8'h10, 7'h56, 6'h39, 2'h0},
        {16'h2635, 8'h20, 7'h56, 6'h39, 2'h0},
        {16'h1f0e, 8'h40, 7'h56, 6'h39, 2'h0},
        {16'hc0ff, 8'h80, 7'h54, 6'h35, 2'h0},
        {16'h0803, 8'h08, 7'h56, 6'h39, 2'h1}};

    always #5 i_mclk = ~i_mclk;

    lic_config_reg dut (.*);

    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // strobes are synchronised inside, so hold each level four clocks
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge i_mclk);
        {i_cs_n, i_wr_n, i_addr, i_data} = {2'h0, a, d};
        repeat (4) @(negedge i_mclk);
        i_wr_n = 1'b1;
        repeat (4) @(negedge i_mclk);
        i_cs_n = 1'b1;
        repeat (3) @(negedge i_mclk);
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(negedge i_mclk);
        {i_cs_n, i_rd_n, i_addr} = {2'h0, a};
        for (int n = 0; o_data_oe !== 1'b1; n++)
        begin
            if (n == 10)
            begin
                // a read that never answers counts against the run
                failures++;
                $display("unexpected read enable: expected 1 seen %b",
                         o_data_oe);
                end_of_test();
            end
            @(negedge i_mclk);
        end
        d = o_data;
        {i_cs_n, i_rd_n} = 2'h3;
        repeat (4) @(negedge i_mclk);
    endtask : rd

    task automatic tk(output int c, s);
        {c, s} = 0;
        @(negedge i_mclk) i_one_second_tick_input = 1'b1;
        repeat (14)
        begin
            @(negedge i_mclk);
            c += int'(o_counter_latch === 1'b1);
            s += int'(o_status_latch === 1'b1);
        end
        i_one_second_tick_input = 1'b0;
        repeat (10) @(negedge i_mclk);
    endtask : tk

    initial
    begin
        repeat (5) @(negedge i_mclk);
        i_reset = 1'b0;
        foreach (rows[i])
        begin
            wr(7'h00, rows[i].w);
            chk("phy", rows[i].oh, o_phy_onehot);
            chk("cols", rows[i].c, o_spe_columns);
            chk("octets", rows[i].o, o_cell_octets);
            chk("loop", rows[i].le[1], o_rx_loopback);
            chk("ext", rows[i].le[0], o_ext_timing);
            chk("levels", rows[i].w[9:3], lvl);
            chk("accept", 1'b1, o_rx_accept);
            rd(7'h00, rd_v);
            chk("readback", rows[i].w, rd_v);
            $display("row %0d done", i);
        end
        // hold only bites while its enable bit is set
        wr(7'h00, 16'h0400);
        i_receive_hold_input = 1'b1;
        repeat (5) @(negedge i_mclk);
        chk("hold", 1'b0, o_rx_accept);
        wr(7'h00, 16'h0000);
        chk("no hold", 1'b1, o_rx_accept);
        // sync stays driven from here on
        i_transmit_sync_input = 1'b1;
        repeat (5) @(negedge i_mclk);
        chk("skip", 1'b1, o_overhead_skip);
        wr(7'h00, 16'h0008);
        chk("no skip", 1'b0, o_overhead_skip);
        $display("hold and framing done");
        // alarm seen before the tick must be held for the next interval
        wr(7'h00, 16'h3000);
        i_line_status = 16'h0005;
        repeat (3) @(negedge i_mclk);
        i_line_status = 16'h0000;
        tk(nc, ns);
        chk("count pulses", 16'h0001, 16'(nc));
        chk("status pulses", 16'h0001, 16'(ns));
        rd(lic_pkg::LIC_LSTAT_ADDR, rd_v);
        chk("held", 16'h0005, rd_v);
        i_line_status = 16'h0100;
        rd(lic_pkg::LIC_LSTAT_ADDR, rd_v);
        chk("second read", 16'h0100, rd_v);
        i_line_status = 16'h0042;
        wr(7'h00, 16'h0000);
        tk(nc, ns);
        chk("no pulses", 16'h0000, 16'(nc + ns));
        rd(lic_pkg::LIC_LSTAT_ADDR, rd_v);
        chk("live", 16'h0042, rd_v);
        rd(7'h05, rd_v);
        chk("unmapped", 16'h0000, rd_v);
        $display("latching done");
        // a stray write and a reset must both leave the word alone
        wr(7'h00, 16'h8080);
        wr(7'h01, 16'hffff);
        @(negedge i_mclk) i_reset = 1'b1;
        repeat (2) @(negedge i_mclk);
        i_reset = 1'b0;
        rd(7'h00, rd_v);
        chk("kept", 16'h8080, rd_v);
        chk("kept cols", 16'h0054, o_spe_columns);
        $display("reset done");
        end_of_test();
    end
endmodule : testbench

`default_nettype wire

//--- core/lic_config_reg.sv
`timescale 1ns/100ps
`default_nettype none

module lic_config_reg
(
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    input  wire logic        i_cs_n,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic [6:0]  i_addr,
    input  wire logic [15:0] i_data,
    output logic      [15:0] o_data,
    output logic             o_data_oe,
    input  wire logic        i_one_second_tick_input,
    input  wire logic        i_receive_hold_input,
    input  wire logic        i_transmit_sync_input,
    input  wire logic [15:0] i_line_status,
    output logic             o_counter_latch,
    output logic             o_status_latch,
    output logic [7:0]       o_phy_onehot,
    output logic [6:0]       o_spe_columns,
    output logic [5:0]       o_cell_octets,
    output logic             o_rx_loopback,
    output logic             o_ext_timing,
    output logic             o_rx_accept,
    output logic             o_scramble_en,
    output logic             o_keep_on_delin_loss,
    output logic             o_hec_delineation,
    output logic             o_parallel_mode,
    output logic             o_ext_framer,
    output logic             o_coder_bypass,
    output logic             o_unframed,
    output logic             o_overhead_skip
);

    // one-hot decode of the framing type field
    function automatic logic [7:0] lic_phy_decode(input logic [2:0] code);
        logic [7:0] oh;
        oh = 8'h00;
        oh[code] = 1'b1;
        return oh;
    endfunction : lic_phy_decode

    // true for the formats that carry a 57-octet plcp frame
    function automatic logic lic_is_plcp_fmt(input lic_pkg::lic_phy_t t);
        return (t == lic_pkg::LIC_PHY_DS3) ||
               (t == lic_pkg::LIC_PHY_E3_FIRST);
    endfunction : lic_is_plcp_fmt

    lic_pkg::lic_state_t st_q;
    lic_pkg::lic_state_t st_d;
    logic [15:0]         cfg_q;
    logic                cfg_we;
    lic_pkg::lic_phy_t   phy_type;
    logic                stat_rd;
    logic                cfg_rd;
    logic                stat_lat_on;

    assign phy_type = lic_pkg::lic_phy_t'(
        cfg_q[lic_pkg::LIC_B_PHY_HI:lic_pkg::LIC_B_PHY_LO]);

    // decodes of the synchronised bus cycle
    always_comb
    begin
        cfg_we  = 1'b0;
        cfg_rd  = 1'b0;
        stat_rd = 1'b0;
        if (st_q.wr_act_p && !st_q.wr_n_s[1]
            && st_q.addr_s2 == lic_pkg::LIC_CFG_ADDR)
        begin
            cfg_we = 1'b0; // write taken at end of strobe, below
        end
        if (st_q.wr_act_p && st_q.wr_n_s[1]
            && st_q.addr_s2 == lic_pkg::LIC_CFG_ADDR)
        begin
            cfg_we = 1'b1;
        end
        if (!st_q.rd_act_p && !st_q.rd_n_s[1] && !st_q.cs_n_s[1])
        begin
            if (st_q.addr_s2 == lic_pkg::LIC_CFG_ADDR)
            begin
                cfg_rd = 1'b1;
            end
            else if (st_q.addr_s2 == lic_pkg::LIC_LSTAT_ADDR)
            begin
                stat_rd = 1'b1;
            end
        end
    end

    assign stat_lat_on = cfg_q[lic_pkg::LIC_B_STAT_LAT];

    // next state of everything except the configuration word
    always_comb
    begin
        st_d = st_q;

        // two-stage synchronisers; only the second stage is read
        st_d.cs_n_s  = {st_q.cs_n_s[0], i_cs_n};
        st_d.rd_n_s  = {st_q.rd_n_s[0], i_rd_n};
        st_d.wr_n_s  = {st_q.wr_n_s[0], i_wr_n};
        st_d.hold_s  = {st_q.hold_s[0], i_receive_hold_input};
        st_d.sync_s  = {st_q.sync_s[0], i_transmit_sync_input};
        st_d.addr_s1 = i_addr;
        st_d.addr_s2 = st_q.addr_s1;
        st_d.din_s1  = i_data;
        st_d.din_s2  = st_q.din_s1;
        st_d.tick_s  = {st_q.tick_s[0], i_one_second_tick_input};
        st_d.tick_p  = st_q.tick_s[1];

        // strobe history for edge detection, gated by chip select
        st_d.rd_act_p = !st_q.rd_n_s[1] && !st_q.cs_n_s[1];
        st_d.wr_act_p = !st_q.wr_n_s[1] && !st_q.cs_n_s[1];

        st_d.cnt_latch = cfg_q[lic_pkg::LIC_B_CNT_LAT]
                       && st_q.tick_s[1] && !st_q.tick_p;
        st_d.stat_latch = stat_lat_on && st_q.tick_s[1] && !st_q.tick_p;

        // accumulate alarms, move them on each interval edge
        if (!stat_lat_on)
        begin
            st_d.stat_acc  = lic_pkg::LIC_ZERO16;
            st_d.stat_lat  = lic_pkg::LIC_ZERO16;
            st_d.read_once = 1'b0;
        end
        else
        begin
            st_d.stat_acc = st_q.stat_acc | i_line_status;
            if (stat_rd && !st_q.read_once)
            begin
                st_d.stat_lat  = lic_pkg::LIC_ZERO16; // cleared by read
                st_d.read_once = 1'b1;
            end
            else if (stat_rd)
            begin
                st_d.stat_acc = i_line_status;
            end
            if (st_d.stat_latch)
            begin
                // set wins over a read clear in the same cycle
                st_d.stat_lat  = st_d.stat_lat | st_q.stat_acc;
                st_d.stat_acc  = i_line_status;
                st_d.read_once = 1'b0;
            end
        end

        // read data is captured once per read strobe and then held
        if (cfg_rd)
        begin
            st_d.dout = cfg_q;
        end
        else if (stat_rd)
        begin
            if (!stat_lat_on)
            begin
                st_d.dout = i_line_status;
            end
            else if (!st_q.read_once)
            begin
                st_d.dout = st_q.stat_lat;
            end
            else
            begin
                st_d.dout = st_q.stat_acc | i_line_status;
            end
        end
        else if (!st_q.rd_act_p && !st_q.rd_n_s[1] && !st_q.cs_n_s[1])
        begin
            st_d.dout = lic_pkg::LIC_ZERO16; // unmapped reads as zero
        end
        st_d.dout_oe = !st_q.rd_n_s[1] && !st_q.cs_n_s[1];

        st_d.phy_onehot = lic_phy_decode(
            cfg_q[lic_pkg::LIC_B_PHY_HI:lic_pkg::LIC_B_PHY_LO]);

        st_d.spe_cols = cfg_q[lic_pkg::LIC_B_STUFF]
                      ? lic_pkg::LIC_COLS_STUFFED
                      : lic_pkg::LIC_COLS_FULL;

        st_d.hec_delin   = cfg_q[lic_pkg::LIC_B_HEC];
        st_d.cell_octets = cfg_q[lic_pkg::LIC_B_HEC]
                         ? lic_pkg::LIC_OCT_HEC
                         : lic_pkg::LIC_OCT_PLCP;

        st_d.rx_loopback = cfg_q[lic_pkg::LIC_B_LOOP]
                         && !cfg_q[lic_pkg::LIC_B_PAR];

        st_d.ext_timing = cfg_q[lic_pkg::LIC_B_EXT_TIM]
                        && !cfg_q[lic_pkg::LIC_B_HEC]
                        && lic_is_plcp_fmt(phy_type);

        st_d.rx_accept = !(cfg_q[lic_pkg::LIC_B_HOLD_EN] && st_q.hold_s[1]);

        st_d.scramble = cfg_q[lic_pkg::LIC_B_SCRAM];
        st_d.keep_on_cell_delineation_loss = cfg_q[lic_pkg::LIC_B_NO_CELL_DELINEATION_LOSS];
        st_d.parallel = cfg_q[lic_pkg::LIC_B_PAR];
        st_d.ext_framer = cfg_q[lic_pkg::LIC_B_EXT_FRM];
        st_d.coder_bypass = cfg_q[lic_pkg::LIC_B_NO_CODER];

        st_d.unframed      = cfg_q[lic_pkg::LIC_B_UNFRAMED];
        st_d.overhead_skip = !cfg_q[lic_pkg::LIC_B_UNFRAMED]
                           && st_q.sync_s[1];
    end

    // state register; strobes idle high so no false edge after reset
    always_ff @(posedge i_mclk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st_q        <= '0;
            st_q.cs_n_s <= lic_pkg::LIC_SYNC_IDLE_HI;
            st_q.rd_n_s <= lic_pkg::LIC_SYNC_IDLE_HI;
            st_q.wr_n_s <= lic_pkg::LIC_SYNC_IDLE_HI;
            st_q.tick_s <= lic_pkg::LIC_SYNC_IDLE_LO;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // no reset on config
    // a write lands at the rising edge of the synchronised strobe
    always_ff @(posedge i_mclk)
    begin
        if (cfg_we)
        begin
            cfg_q <= st_q.din_s2;
        end
    end

    // every output straight from the state register
    assign o_data               = st_q.dout;
    assign o_data_oe            = st_q.dout_oe;
    assign o_counter_latch      = st_q.cnt_latch;
    assign o_status_latch       = st_q.stat_latch;
    assign o_phy_onehot         = st_q.phy_onehot;
    assign o_spe_columns        = st_q.spe_cols;
    assign o_cell_octets        = st_q.cell_octets;
    assign o_rx_loopback        = st_q.rx_loopback;
    assign o_ext_timing         = st_q.ext_timing;
    assign o_rx_accept          = st_q.rx_accept;
    assign o_scramble_en        = st_q.scramble;
    assign o_keep_on_delin_loss = st_q.keep_on_cell_delineation_loss;
    assign o_hec_delineation    = st_q.hec_delin;
    assign o_parallel_mode      = st_q.parallel;
    assign o_ext_framer         = st_q.ext_framer;
    assign o_coder_bypass       = st_q.coder_bypass;
    assign o_unframed           = st_q.unframed;
    assign o_overhead_skip      = st_q.overhead_skip;

endmodule : lic_config_reg

`default_nettype wire

//--- core/lic_pkg.sv
package lic_pkg;

    // register indices on the seven address pins (byte address / 2)
    localparam logic [6:0] LIC_CFG_ADDR   = 7'h00;
    localparam logic [6:0] LIC_LSTAT_ADDR = 7'h38;

    // configuration field positions
    localparam int LIC_B_STUFF    = 15;
    localparam int LIC_B_LOOP     = 14;
    localparam int LIC_B_CNT_LAT  = 13;
    localparam int LIC_B_STAT_LAT = 12;
    localparam int LIC_B_EXT_TIM  = 11;
    localparam int LIC_B_HOLD_EN  = 10;
    localparam int LIC_B_SCRAM    = 9;
    localparam int LIC_B_NO_CELL_DELINEATION_LOSS  = 8;
    localparam int LIC_B_HEC      = 7;
    localparam int LIC_B_PAR      = 6;
    localparam int LIC_B_EXT_FRM  = 5;
    localparam int LIC_B_NO_CODER = 4;
    localparam int LIC_B_UNFRAMED = 3;
    localparam int LIC_B_PHY_HI   = 2;
    localparam int LIC_B_PHY_LO   = 0;

    // payload geometry
    localparam logic [6:0] LIC_COLS_STUFFED = 7'h54; // 84 columns
    localparam logic [6:0] LIC_COLS_FULL    = 7'h56; // 86 columns
    localparam logic [5:0] LIC_OCT_HEC      = 6'h35; // 53-octet cells
    localparam logic [5:0] LIC_OCT_PLCP     = 6'h39; // 57-octet cells

    // values after reset
    localparam logic [15:0] LIC_ZERO16 = 16'h0000;
    localparam logic [1:0]  LIC_SYNC_IDLE_HI = 2'h3; // strobes idle high
    localparam logic [1:0]  LIC_SYNC_IDLE_LO = 2'h0;

    // line framing types, in field code order
    typedef enum logic [2:0] {
        LIC_PHY_DS1,
        LIC_PHY_E1,
        LIC_PHY_DS3,
        LIC_PHY_E3_FIRST,
        LIC_PHY_E3_DIRECT,
        LIC_PHY_E4,
        LIC_PHY_STS1,
        LIC_PHY_STS3C
    } lic_phy_t;

    // whole state of the block except the configuration word
    typedef struct packed {
        logic [1:0]  cs_n_s;
        logic [1:0]  rd_n_s;
        logic [1:0]  wr_n_s;
        logic [1:0]  tick_s;
        logic [1:0]  hold_s;
        logic [1:0]  sync_s;
        logic        rd_act_p;
        logic        wr_act_p;
        logic        tick_p;
        logic [6:0]  addr_s1;
        logic [6:0]  addr_s2;
        logic [15:0] din_s1;
        logic [15:0] din_s2;
        logic [15:0] dout;
        logic        dout_oe;
        logic [15:0] stat_acc;
        logic [15:0] stat_lat;
        logic        read_once;
        logic        cnt_latch;
        logic        stat_latch;
        logic [7:0]  phy_onehot;
        logic [6:0]  spe_cols;
        logic [5:0]  cell_octets;
        logic        rx_loopback;
        logic        ext_timing;
        logic        rx_accept;
        logic        scramble;
        logic        keep_on_cell_delineation_loss;
        logic        hec_delin;
        logic        parallel;
        logic        ext_framer;
        logic        coder_bypass;
        logic        unframed;
        logic        overhead_skip;
    } lic_state_t;

endpackage : lic_pkg
